// ---- hdl/skip_xor_pkg.sv ----
// Package of opcodes, field positions, phases and reset values for the execution block.
package skip_xor_pkg;

    // ====================================================================
    // Q phases within one instruction cycle
    // ====================================================================
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [1:0] PH_STEP = 2'h1;

    // ====================================================================
    // Instruction encodings and field positions
    // ====================================================================
    localparam logic [6:0] OP_TEST_SKIP = 7'h33;
    localparam logic [7:0] OP_XOR_IMM = 8'h0A;
    localparam logic [13:0] OP_TABLE_STORE = 14'h0003;
    localparam logic [15:0] OP_NO_OPERATION = 16'h0000;
    localparam int TEST_SKIP_MSB = 15;
    localparam int TEST_SKIP_LSB = 9;
    localparam int XOR_OP_LSB = 8;
    localparam int TABLE_OP_LSB = 2;
    localparam int ACCESS_SEL_BIT = 8;

    // Table store pointer modes held in the two lowest opcode bits.
    localparam logic [1:0] TBL_PLAIN = 2'h0;
    localparam logic [1:0] TBL_POST_INC = 2'h1;
    localparam logic [1:0] TBL_POST_DEC = 2'h2;
    localparam logic [1:0] TBL_PRE_INC = 2'h3;

    // ====================================================================
    // Operand addressing
    // ====================================================================
    localparam logic [7:0] ACCESS_LOW_MAX = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [11:0] FILE_ADDR_ZERO = 12'h000;

    // ====================================================================
    // Widths and reset values
    // ====================================================================
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [21:0] TPTR_RESET = 22'h000000;
    localparam logic [21:0] TPTR_STEP = 22'h000001;
    localparam int SIGN_BIT = 7;

    typedef enum logic [1:0] {S_RUN, S_SKIP1, S_SKIP2, S_TBL} exec_state_e;

endpackage

// ---- hdl/operand_addr.sv ----
// Operand address generator for byte-oriented file register access.
`timescale 1ns/1ns

module operand_addr
(
    input wire logic [7:0] file_field_in,
    input wire logic access_sel_in,
    input wire logic extended_in,
    input wire logic [3:0] bank_select_reg_in,
    input wire logic [11:0] fsr2_in,
    output logic [11:0] file_addr_out
);
    import skip_xor_pkg::*;

    // ====================================================================
    // Address selection
    // ====================================================================
    // Indexed mode only claims the lower access range, so the special
    // function registers in the upper access range stay reachable.
    always_comb
    begin
        if (access_sel_in)
        begin
            file_addr_out = {bank_select_reg_in, file_field_in};
        end
        else if (extended_in && (file_field_in <= ACCESS_LOW_MAX))
        begin
            file_addr_out = 12'(fsr2_in + {4'h0, file_field_in});
        end
        else if (file_field_in <= ACCESS_LOW_MAX)
        begin
            file_addr_out = {ACCESS_LOW_BANK, file_field_in};
        end
        else
        begin
            file_addr_out = {ACCESS_HIGH_BANK, file_field_in};
        end
    end

endmodule // operand_addr

// ---- hdl/skip_test_xor_literal_exec.sv ----
// Execution unit for test-and-skip, xor-immediate and the table store tail.
// Summary of operation
// - Zero operand on test-and-skip drops the prefetched word, runs a no-operation cycle.
// - Taken skip over a two-word successor takes three cycles, flushing both words.
// - Access-select 0 uses the access bank; 1 uses the bank select register.
// - Access-select 0, extended set on, address up to 95: indexed offset addressing.
// - Every extra skip cycle does nothing in all four Q phases.
// - Xor-immediate writes accumulator XOR 8-bit literal back, one word, one cycle.
// - Xor-immediate updates only negative and zero; test-and-skip changes no flags.
// - Table store second cycle writes table byte latch into holding register at pointer.
`timescale 1ns/1ns

module skip_test_xor_literal_exec
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic next_two_word_in,
    input wire logic extended_in,
    input wire logic [3:0] bank_select_reg_in,
    input wire logic [11:0] fsr2_in,
    input wire logic [7:0] file_data_in,
    input wire logic [7:0] table_byte_latch_in,
    input wire logic acc_load_in,
    input wire logic [7:0] acc_data_in,
    input wire logic tptr_load_in,
    input wire logic [21:0] tptr_data_in,
    output logic [1:0] phase_out,
    output logic [11:0] file_addr_out,
    output logic file_rd_out,
    output logic flush_out,
    output logic nop_cycle_out,
    output logic [7:0] acc_out,
    output logic flag_n_out,
    output logic flag_z_out,
    output logic [21:0] table_pointer_out,
    output logic hold_wr_out,
    output logic [21:0] hold_addr_out,
    output logic [7:0] hold_data_out
);
    import skip_xor_pkg::*;

    // ====================================================================
    // State
    // ====================================================================
    exec_state_e st;
    exec_state_e next_st;
    logic [1:0] q;
    logic [1:0] next_q;
    logic [15:0] ir;
    logic [15:0] next_ir;
    logic zero;
    logic next_zero;
    logic two;
    logic next_two;
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic fn;
    logic next_fn;
    logic fz;
    logic next_fz;
    logic [21:0] tptr;
    logic [21:0] next_tptr;
    logic [7:0] tbyte;
    logic [7:0] next_tbyte;
    logic [11:0] faddr;
    logic [11:0] next_faddr;
    logic frd;
    logic next_frd;
    logic flush;
    logic next_flush;
    logic no_operation;
    logic next_nop;
    logic hwr;
    logic next_hwr;
    logic [21:0] haddr;
    logic [21:0] next_haddr;
    logic [7:0] hdata;
    logic [7:0] next_hdata;
    logic [11:0] op_addr;
    logic is_tst;
    logic is_xor;
    logic is_tbl;
    logic [7:0] xor_res;

    // ====================================================================
    // Decode and operand address
    // ====================================================================
    // Decode is taken from the latched word, so a late instr_in change
    // after Q1 cannot disturb an instruction already in flight.
    assign is_tst = (ir[TEST_SKIP_MSB:TEST_SKIP_LSB] == OP_TEST_SKIP);
    assign is_xor = (ir[TEST_SKIP_MSB:XOR_OP_LSB] == OP_XOR_IMM);
    assign is_tbl = (ir[TEST_SKIP_MSB:TABLE_OP_LSB] == OP_TABLE_STORE);
    assign xor_res = acc ^ ir[7:0];

    operand_addr operand_addr_inst
    (
        .file_field_in(ir[7:0]),
        .access_sel_in(ir[ACCESS_SEL_BIT]),
        .extended_in(extended_in),
        .bank_select_reg_in(bank_select_reg_in),
        .fsr2_in(fsr2_in),
        .file_addr_out(op_addr)
    );

    // ====================================================================
    // Next-state logic
    // ====================================================================
    always_comb
    begin
        next_q = 2'(q + PH_STEP);
        next_st = st;
        next_ir = ir;
        next_zero = zero;
        next_two = two;
        next_acc = acc_load_in ? acc_data_in : acc;
        next_fn = fn;
        next_fz = fz;
        next_tptr = tptr_load_in ? tptr_data_in : tptr;
        next_tbyte = tbyte;
        next_faddr = faddr;
        next_frd = 1'b0;
        next_flush = 1'b0;
        next_nop = no_operation;
        next_hwr = 1'b0;
        next_haddr = haddr;
        next_hdata = hdata;
        case (st)
            S_RUN:
            begin
                case (q)
                    PH_Q1:
                    begin
                        next_ir = instr_valid_in ? instr_in : OP_NO_OPERATION;
                    end
                    PH_Q2:
                    begin
                        if (is_tst)
                        begin
                            next_faddr = op_addr;
                            next_frd = 1'b1;
                        end
                    end
                    PH_Q3:
                    begin
                        if (is_tst)
                        begin
                            next_zero = (file_data_in == BYTE_ZERO);
                            next_two = next_two_word_in;
                        end
                    end
                    PH_Q4:
                    begin
                        if (is_xor)
                        begin
                            next_acc = xor_res;
                            next_fz = (xor_res == BYTE_ZERO);
                            next_fn = xor_res[SIGN_BIT];
                        end
                        else if (is_tst && zero)
                        begin
                            next_flush = 1'b1;
                            next_nop = 1'b1;
                            next_st = S_SKIP1;
                        end
                        else if (is_tbl)
                        begin
                            if (ir[1:0] == TBL_PRE_INC)
                            begin
                                next_tptr = 22'(tptr + TPTR_STEP);
                            end
                            next_st = S_TBL;
                        end
                    end
                    default:
                    begin
                        next_st = S_RUN;
                    end
                endcase
            end
            S_SKIP1:
            begin
                // No fetch, read or write happens in a flushed cycle.
                if (q == PH_Q4)
                begin
                    next_st = two ? S_SKIP2 : S_RUN;
                    next_flush = two;
                    next_nop = two;
                end
            end
            S_SKIP2:
            begin
                if (q == PH_Q4)
                begin
                    next_st = S_RUN;
                    next_nop = 1'b0;
                end
            end
            S_TBL:
            begin
                if (q == PH_Q2)
                begin
                    next_tbyte = table_byte_latch_in;
                end
                else if (q == PH_Q4)
                begin
                    next_hwr = 1'b1;
                    next_haddr = tptr;
                    next_hdata = tbyte;
                    if (ir[1:0] == TBL_POST_INC)
                    begin
                        next_tptr = 22'(tptr + TPTR_STEP);
                    end
                    else if (ir[1:0] == TBL_POST_DEC)
                    begin
                        next_tptr = 22'(tptr - TPTR_STEP);
                    end
                    next_st = S_RUN;
                end
            end
            default:
            begin
                next_st = S_RUN;
            end
        endcase
    end

    // ====================================================================
    // Registers
    // ====================================================================
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st <= S_RUN;
            q <= PH_Q1;
            ir <= OP_NO_OPERATION;
            zero <= 1'b0;
            two <= 1'b0;
            acc <= BYTE_ZERO;
            fn <= 1'b0;
            fz <= 1'b0;
            tptr <= TPTR_RESET;
            tbyte <= BYTE_ZERO;
            faddr <= FILE_ADDR_ZERO;
            frd <= 1'b0;
            flush <= 1'b0;
            no_operation <= 1'b0;
            hwr <= 1'b0;
            haddr <= TPTR_RESET;
            hdata <= BYTE_ZERO;
        end
        else
        begin
            st <= next_st;
            q <= next_q;
            ir <= next_ir;
            zero <= next_zero;
            two <= next_two;
            acc <= next_acc;
            fn <= next_fn;
            fz <= next_fz;
            tptr <= next_tptr;
            tbyte <= next_tbyte;
            faddr <= next_faddr;
            frd <= next_frd;
            flush <= next_flush;
            no_operation <= next_nop;
            hwr <= next_hwr;
            haddr <= next_haddr;
            hdata <= next_hdata;
        end
    end

    // Outputs are the flip-flops themselves.
    assign phase_out = q;
    assign file_addr_out = faddr;
    assign file_rd_out = frd;
    assign flush_out = flush;
    assign nop_cycle_out = no_operation;
    assign acc_out = acc;
    assign flag_n_out = fn;
    assign flag_z_out = fz;
    assign table_pointer_out = tptr;
    assign hold_wr_out = hwr;
    assign hold_addr_out = haddr;
    assign hold_data_out = hdata;

    // ====================================================================
    // Assertions
    // ====================================================================
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    skip_flush_a: assert property (
        (st == S_RUN && q == PH_Q4 && is_tst && zero) |=> flush && no_operation && st == S_SKIP1)
        else $error("Taken skip did not flush the prefetched word.");

    skip_len_a: assert property (
        ($rose(no_operation) && !two) |-> no_operation[*4] ##1 !no_operation)
        else $error("Single skip did not last exactly one cycle.");

    two_word_len_a: assert property (
        ($rose(no_operation) && two) |-> no_operation[*8] ##1 !no_operation)
        else $error("Skip over a two-word successor did not last two cycles.");

    bank_sel_a: assert property (
        (frd && ir[ACCESS_SEL_BIT]) |-> faddr == {$past(bank_select_reg_in), ir[7:0]})
        else $error("Banked operand address is wrong.");

    indexed_mode_a: assert property (
        (frd && !ir[ACCESS_SEL_BIT] && $past(extended_in) && ir[7:0] <= ACCESS_LOW_MAX)
        |-> faddr == 12'($past(fsr2_in) + {4'h0, ir[7:0]}))
        else $error("Indexed operand address is wrong.");

    skip_quiet_a: assert property (
        (no_operation && !$past(acc_load_in) && !$past(tptr_load_in))
        |-> !frd && !hwr && $stable(acc) && $stable(tptr) && $stable(fz) && $stable(fn))
        else $error("Activity seen during a skipped cycle.");

    xor_result_a: assert property (
        (st == S_RUN && q == PH_Q4 && is_xor) |=> acc == $past(xor_res))
        else $error("Xor-immediate result is wrong.");

    xor_flags_a: assert property (
        (st == S_RUN && q == PH_Q4 && is_xor) |=> fz == (acc == BYTE_ZERO) && fn == acc[SIGN_BIT])
        else $error("Xor-immediate flags are wrong.");

    skip_flags_a: assert property (
        (st == S_RUN && q == PH_Q4 && is_tst) |=> $stable(fz) && $stable(fn))
        else $error("Test-and-skip changed a flag.");

    table_write_a: assert property (
        $rose(hwr) |-> hdata == $past(table_byte_latch_in, 3) && haddr == $past(tptr))
        else $error("Holding register write carries the wrong byte or address.");

    post_inc_a: assert property (
        ($rose(hwr) && ir[1:0] == TBL_POST_INC && !$past(tptr_load_in))
        |-> tptr == 22'(haddr + TPTR_STEP))
        else $error("Post-increment pointer not bumped after the write.");

endmodule // skip_test_xor_literal_exec

// ---- dv/skip_test_xor_literal_exec_bench.sv ----
// Self-checking testbench for the test-and-skip, xor-immediate and table store execution block.
`timescale 1ns/1ns

module skip_test_xor_literal_exec_bench;
    import skip_xor_pkg::*;

    // ====================================================================
    // Stimulus and observed signals
    // ====================================================================
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic next_two_word_in = 1'b0;
    logic extended_in = 1'b0;
    logic [3:0] bank_select_reg_in = 4'h0;
    logic [11:0] fsr2_in = 12'h000;
    logic [7:0] file_data_in = 8'h00;
    logic [7:0] table_byte_latch_in = 8'h00;
    logic acc_load_in = 1'b0;
    logic [7:0] acc_data_in = 8'h00;
    logic tptr_load_in = 1'b0;
    logic [21:0] tptr_data_in = 22'h000000;
    logic [1:0] phase_out;
    logic [11:0] file_addr_out;
    logic file_rd_out;
    logic flush_out;
    logic nop_cycle_out;
    logic [7:0] acc_out;
    logic flag_n_out;
    logic flag_z_out;
    logic [21:0] table_pointer_out;
    logic hold_wr_out;
    logic [21:0] hold_addr_out;
    logic [7:0] hold_data_out;
    int num_errors = 0;
    int checked = 0;
    int rd_cnt, fl_cnt, nop_cnt, wr_cnt;
    logic [11:0] seen_addr;

    skip_test_xor_literal_exec skip_test_xor_literal_exec_inst
    (
        .clk_in(clk_in), .resetn_in(resetn_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .next_two_word_in(next_two_word_in), .extended_in(extended_in),
        .bank_select_reg_in(bank_select_reg_in), .fsr2_in(fsr2_in),
        .file_data_in(file_data_in), .table_byte_latch_in(table_byte_latch_in),
        .acc_load_in(acc_load_in), .acc_data_in(acc_data_in), .tptr_load_in(tptr_load_in),
        .tptr_data_in(tptr_data_in), .phase_out(phase_out), .file_addr_out(file_addr_out),
        .file_rd_out(file_rd_out), .flush_out(flush_out), .nop_cycle_out(nop_cycle_out),
        .acc_out(acc_out), .flag_n_out(flag_n_out), .flag_z_out(flag_z_out),
        .table_pointer_out(table_pointer_out), .hold_wr_out(hold_wr_out),
        .hold_addr_out(hold_addr_out), .hold_data_out(hold_data_out)
    );

    // ====================================================================
    // Clock and shared tasks
    // ====================================================================
    // The 20 MHz clock; inputs move only on its falling edge to avoid races.
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end

    // Compares one value, counting every comparison and every mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Offers a word at a Q1 edge outside a skip; the counters restart with it.
    task automatic issue(input logic [15:0] w);
        int guard;
        guard = 0;
        @(negedge clk_in);
        while (!(phase_out === PH_Q1 && nop_cycle_out === 1'b0) && guard < 40)
        begin
            @(negedge clk_in);
            guard++;
        end
        // A word that never finds a free Q1 slot is a hang and counts as a mismatch.
        if (guard >= 40)
        begin
            num_errors++;
            $display("ERROR at %0t ns: no free decode slot for the word", $time);
        end
        instr_valid_in = 1'b1;
        instr_in = w;
        rd_cnt = 0;
        fl_cnt = 0;
        nop_cnt = 0;
        wr_cnt = 0;
        @(negedge clk_in);
        instr_valid_in = 1'b0;
        instr_in = OP_NO_OPERATION;
    endtask

    // Watches settled outputs for n cycles and tallies strobes and skip cycles.
    task automatic run(input int n);
        repeat (n)
        begin
            @(negedge clk_in);
            if (file_rd_out === 1'b1)
            begin
                rd_cnt++;
                seen_addr = file_addr_out;
            end
            fl_cnt += (flush_out === 1'b1) ? 1 : 0;
            nop_cnt += (nop_cycle_out === 1'b1) ? 1 : 0;
            wr_cnt += (hold_wr_out === 1'b1) ? 1 : 0;
        end
    endtask

    // ====================================================================
    // Scenarios
    // ====================================================================
    // Loads the accumulator, xors a literal and checks result and flags.
    task automatic do_xor(input logic [7:0] a, input logic [7:0] k, input logic [7:0] r);
        @(negedge clk_in);
        acc_load_in = 1'b1;
        acc_data_in = a;
        @(negedge clk_in);
        acc_load_in = 1'b0;
        issue({OP_XOR_IMM, k});
        run(6);
        check(acc_out, r, "xor result");
        check(flag_n_out, r[7], "negative flag");
        check(flag_z_out, r == 8'h00, "zero flag");
        check(nop_cnt, 0, "xor skip cycles");
        check(phase_out, PH_Q4, "xor phase count");
    endtask

    // Runs one test-and-skip; zero data must flush one word, or two over a two-word successor.
    task automatic do_skip(input logic a, input logic ext, input logic [7:0] f,
                           input logic [3:0] bank_select_reg, input logic [11:0] idx, input logic [7:0] d,
                           input logic two, input logic [11:0] exp_addr);
        int exp_fl;
        logic [7:0] acc_before;
        logic n_before;
        logic z_before;
        exp_fl = (d == 8'h00) ? (two ? 2 : 1) : 0;
        acc_before = acc_out;
        n_before = flag_n_out;
        z_before = flag_z_out;
        extended_in = ext;
        bank_select_reg_in = bank_select_reg;
        fsr2_in = idx;
        file_data_in = d;
        next_two_word_in = two;
        issue({OP_TEST_SKIP, a, f});
        run(14);
        check(rd_cnt, 1, "operand reads");
        check(seen_addr, exp_addr, "operand address");
        check(fl_cnt, exp_fl, "flushed words");
        check(nop_cnt, 4 * exp_fl, "skip cycles");
        check({acc_out, flag_n_out, flag_z_out}, {acc_before, n_before, z_before}, "flags");
    endtask

    // Runs one table store from a loaded pointer and checks the write and the pointer.
    task automatic do_table(input logic [1:0] mode, input logic [21:0] ptr, input logic [7:0] b,
                            input logic [21:0] exp_addr, input logic [21:0] exp_ptr);
        @(negedge clk_in);
        tptr_load_in = 1'b1;
        tptr_data_in = ptr;
        @(negedge clk_in);
        tptr_load_in = 1'b0;
        table_byte_latch_in = b;
        issue({OP_TABLE_STORE, mode});
        run(10);
        check(wr_cnt, 1, "holding writes");
        check(hold_addr_out, exp_addr, "holding address");
        check(hold_data_out, b, "holding data");
        check(table_pointer_out, exp_ptr, "table pointer");
    endtask

    // ====================================================================
    // Main sequence and watchdog
    // ====================================================================
    // Reset for three cycles, then every scenario in turn.
    initial
    begin
        repeat (3) @(negedge clk_in);
        check({acc_out, flag_n_out, flag_z_out, hold_wr_out}, 0, "reset state");
        resetn_in = 1'b1;
        do_xor(8'hB5, 8'hAF, 8'h1A);
        do_xor(8'h3C, 8'h3C, 8'h00);
        do_xor(8'h01, 8'h81, 8'h80);
        do_skip(1'b0, 1'b0, 8'h20, 4'h7, 12'h123, 8'h00, 1'b0, 12'h020);
        do_skip(1'b0, 1'b0, 8'h80, 4'h7, 12'h123, 8'h00, 1'b1, 12'hF80);
        do_skip(1'b1, 1'b0, 8'h45, 4'h3, 12'h123, 8'h05, 1'b1, 12'h345);
        do_skip(1'b0, 1'b1, 8'h10, 4'h3, 12'h123, 8'h00, 1'b0, 12'h133);
        do_skip(1'b0, 1'b1, 8'h60, 4'h3, 12'h123, 8'h01, 1'b0, 12'hF60);
        do_skip(1'b0, 1'b1, 8'h5F, 4'h3, 12'hFF0, 8'h00, 1'b1, 12'h04F);
        do_skip(1'b1, 1'b1, 8'h05, 4'hA, 12'h123, 8'h00, 1'b1, 12'hA05);
        do_table(TBL_POST_INC, 22'h00A356, 8'h55, 22'h00A356, 22'h00A357);
        do_table(TBL_PRE_INC, 22'h01389A, 8'h34, 22'h01389B, 22'h01389B);
        do_table(TBL_POST_DEC, 22'h000000, 8'hA5, 22'h000000, 22'h3FFFFF);
        do_table(TBL_PLAIN, 22'h001234, 8'h0F, 22'h001234, 22'h001234);
        print_verdict();
    end

    // Cuts a hang short well beyond the few hundred cycles the scenarios need.
    initial
    begin
        #250000;
        num_errors++;
        $display("ERROR at %0t ns: watchdog expired", $time);
        print_verdict();
    end

endmodule // skip_test_xor_literal_exec_bench
